// ==== core/loadswitch_buck1_config_regs.sv ====
// Load-switch configuration and buck-1 control registers with their effects.
// Assumes a serial decoder on ref_clk presents register accesses and the
// unlock and apply strobes; comparator outputs arrive asynchronously.
//
// Functional notes
// - load-switch register at 0x15, reset 0x00
// - cut bit turns switch off on power-fail
// - discharge bit discharges switch output while off
// - buck-1 register at 0x16, reset 0x99
// - buck-1 writes need a completed unlock
// - buck-1 write blanks voltage fault reports 5 ms
// - new voltage code applies only on go
// - bit 7 selects pulse-skip, else forced fixed-frequency
// - bits 5-0 hold voltage code, reset 19h
`timescale 1ns/1ns
`include "lsbc_params.svh"

module loadswitch_buck1_config_regs
	import lsbc_pkg::*;
#(
	parameter int unsigned BLANK_CYCLES = `BLANK_TIME_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
) (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	// Register access from the serial decoder
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [`ADDR_W-1:0]        reg_addr,
	input  wire logic [7:0]                reg_wdata,
	output logic      [7:0]                reg_rdata_q,
	input  wire logic                      unlock_ok,
	// Apply strobes from the go register
	input  wire logic                      voltage_apply_go,
	input  wire logic                      voltage_apply_alt,
	// Load switch control
	input  wire logic [`NUM_SWITCHES-1:0]  sw_on_req,
	input  wire logic                      power_fail_out_n,
	output logic      [`NUM_SWITCHES-1:0]  sw_on_q,
	output logic      [`NUM_SWITCHES-1:0]  sw_discharge_q,
	// Buck-1 control
	output logic                           pulse_skip_en_q,
	output vout_code_t                     buck1_vout_code_q,
	input  wire logic                      buck1_ov_raw,
	input  wire logic                      buck1_uv_raw,
	output logic                           buck1_fault_q,
	output logic                           buck1_blank_q
);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers

	logic [1:0] pf_sync_q;
	logic [1:0] ov_sync_q;
	logic [1:0] uv_sync_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pf_sync_q <= 2'h3;
			ov_sync_q <= 2'h0;
			uv_sync_q <= 2'h0;
		end else begin
			pf_sync_q <= {pf_sync_q[0], power_fail_out_n};
			ov_sync_q <= {ov_sync_q[0], buck1_ov_raw};
			uv_sync_q <= {uv_sync_q[0], buck1_uv_raw};
		end
	end

	logic pf_n_s;
	assign pf_n_s = pf_sync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Register writes

	logic                     ls_hit;
	logic                     buck_hit;
	logic                     ls_wr_ok;
	logic                     buck_wr_ok;
	logic [`LS_CUT_MSB:0]     ls_cfg_q;
	logic                     pfm_q;
	vout_code_t               code_q;

	// Reset images, sliced per field so no bit is dropped silently
	localparam logic [7:0] LS_RST   = `RST_LOAD_SWITCH_CONFIG;
	localparam logic [7:0] BUCK_RST = `RST_BUCK1_CONTROL;

	assign ls_hit     = (reg_addr == `ADDR_LOAD_SWITCH_CONFIG);
	assign buck_hit   = (reg_addr == `ADDR_BUCK1_CONTROL);
	assign ls_wr_ok   = reg_wr && ls_hit && unlock_ok;
	assign buck_wr_ok = reg_wr && buck_hit && unlock_ok;

	// Only writable bits are stored, so reserved bits cannot hold stray data
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ls_cfg_q <= LS_RST[`LS_CUT_MSB:0];
		end else if (ls_wr_ok) begin
			ls_cfg_q <= reg_wdata[`LS_CUT_MSB:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pfm_q  <= BUCK_RST[`BUCK_PFM_BIT];
			code_q <= vout_code_t'(`RST_BUCK1_CONTROL);
		end else if (buck_wr_ok) begin
			pfm_q  <= reg_wdata[`BUCK_PFM_BIT];
			code_q <= reg_wdata[`BUCK_CODE_MSB:`BUCK_CODE_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			if (ls_hit) begin
				reg_rdata_q <= {2'h0, ls_cfg_q};
			end else if (buck_hit) begin
				reg_rdata_q <= {pfm_q, 1'h0, code_q};
			end else begin
				reg_rdata_q <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Load switches

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_SWITCHES; gi++) begin : g_sw
			logic on_d;
			assign on_d = sw_on_req[gi] && !(ls_cfg_q[`LS_CUT_LSB + gi] && !pf_n_s);
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					sw_on_q[gi]        <= 1'b0;
					sw_discharge_q[gi] <= 1'b0;
				end else begin
					sw_on_q[gi]        <= on_d;
					// Tied to the next on state so discharge never fights a closing switch
					sw_discharge_q[gi] <= ls_cfg_q[`LS_DIS_LSB + gi] && !on_d;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Buck-1 mode and voltage

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pulse_skip_en_q <= BUCK_RST[`BUCK_PFM_BIT];
		end else begin
			pulse_skip_en_q <= pfm_q;
		end
	end

	// The converter sees the stored code only on go, so a half-written
	// sequence of codes never reaches the output
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			buck1_vout_code_q <= vout_code_t'(`RST_BUCK1_CONTROL);
		end else if (voltage_apply_go || voltage_apply_alt) begin
			buck1_vout_code_q <= code_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Monitor blanking

	blank_state_t             state_q;
	logic [`BLANK_CNT_W-1:0]  blank_cnt_q;
	localparam logic [`BLANK_CNT_W-1:0] BLANK_LAST = `BLANK_CNT_W'(BLANK_CYCLES - 1);

	// A write during blanking restarts the full interval
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q     <= ST_MONITOR;
			blank_cnt_q <= '0;
		end else begin
			case (state_q)
				ST_MONITOR: begin
					if (buck_wr_ok) begin
						state_q     <= ST_BLANK;
						blank_cnt_q <= '0;
					end
				end
				ST_BLANK: begin
					if (buck_wr_ok) begin
						blank_cnt_q <= '0;
					end else if (blank_cnt_q == BLANK_LAST) begin
						state_q     <= ST_MONITOR;
						blank_cnt_q <= '0;
					end else begin
						blank_cnt_q <= blank_cnt_q + 1'b1;
					end
				end
				default: begin
					state_q <= ST_MONITOR;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			buck1_fault_q <= 1'b0;
			buck1_blank_q <= 1'b0;
		end else begin
			buck1_fault_q <= (ov_sync_q[1] || uv_sync_q[1]) && (state_q == ST_MONITOR)
				&& !buck_wr_ok;
			buck1_blank_q <= (state_q == ST_BLANK) || buck_wr_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_ls_locked;
		reg_wr && ls_hit && !unlock_ok |=> $stable(ls_cfg_q);
	endproperty
	a_ls_locked: assert property (p_ls_locked) else $error("locked load-switch write stored");

	property p_buck_locked;
		reg_wr && buck_hit && !unlock_ok |=> $stable(code_q) && $stable(pfm_q);
	endproperty
	a_buck_locked: assert property (p_buck_locked) else $error("locked buck write stored");

	property p_ls_read;
		reg_rd && ls_hit |=> reg_rdata_q[7:6] == 2'h0 && reg_rdata_q[5:0] == $past(ls_cfg_q);
	endproperty
	a_ls_read: assert property (p_ls_read) else $error("load-switch readback wrong");

	property p_buck_read;
		reg_rd && buck_hit |=> reg_rdata_q[`BUCK_RSVD_BIT] == 1'b0
			&& reg_rdata_q[`BUCK_CODE_MSB:0] == $past(code_q);
	endproperty
	a_buck_read: assert property (p_buck_read) else $error("buck readback wrong");

	property p_cut;
		ls_cfg_q[`LS_CUT_LSB] && !pf_n_s |=> !sw_on_q[0]
			&& sw_discharge_q[0] == $past(ls_cfg_q[`LS_DIS_LSB]);
	endproperty
	a_cut: assert property (p_cut) else $error("switch 1 stayed on in power fail");

	property p_no_cut;
		!ls_cfg_q[`LS_CUT_LSB + 1] |=> sw_on_q[1] == $past(sw_on_req[1]);
	endproperty
	a_no_cut: assert property (p_no_cut) else $error("switch 2 cut without enable");

	property p_discharge;
		sw_on_q[2] |-> !sw_discharge_q[2];
	endproperty
	a_discharge: assert property (p_discharge) else $error("discharge while switch on");

	property p_hold_code;
		!voltage_apply_go && !voltage_apply_alt |=> $stable(buck1_vout_code_q);
	endproperty
	a_hold_code: assert property (p_hold_code) else $error("code applied without go");

	property p_apply_code;
		voltage_apply_go || voltage_apply_alt |=> buck1_vout_code_q == $past(code_q);
	endproperty
	a_apply_code: assert property (p_apply_code) else $error("go did not apply code");

	property p_pfm;
		##1 1'b1 |-> pulse_skip_en_q == $past(pfm_q);
	endproperty
	a_pfm: assert property (p_pfm) else $error("pulse-skip enable lags wrongly");

	property p_blank_mask;
		buck_wr_ok |=> buck1_blank_q && !buck1_fault_q ##1 state_q == ST_BLANK;
	endproperty
	a_blank_mask: assert property (p_blank_mask) else $error("fault seen in blanking");

	property p_blank_len;
		state_q == ST_BLANK |-> blank_cnt_q <= BLANK_LAST;
	endproperty
	a_blank_len: assert property (p_blank_len) else $error("blanking counter overran");

	property p_ls_write;
		ls_wr_ok |=> ls_cfg_q == $past(reg_wdata[`LS_CUT_MSB:0]);
	endproperty
	a_ls_write: assert property (p_ls_write) else $error("load-switch write lost");

	property p_buck_write;
		buck_wr_ok |=> code_q == $past(reg_wdata[`BUCK_CODE_MSB:`BUCK_CODE_LSB])
			&& pfm_q == $past(reg_wdata[`BUCK_PFM_BIT]);
	endproperty
	a_buck_write: assert property (p_buck_write) else $error("buck write lost");

	property p_blank_restart;
		state_q == ST_BLANK && buck_wr_ok |=> state_q == ST_BLANK && blank_cnt_q == '0;
	endproperty
	a_blank_restart: assert property (p_blank_restart) else $error("blanking not restarted");

	property p_blank_end;
		state_q == ST_BLANK && blank_cnt_q == BLANK_LAST && !buck_wr_ok
			|=> state_q == ST_MONITOR;
	endproperty
	a_blank_end: assert property (p_blank_end) else $error("blanking did not end");

	property p_fault_pass;
		(ov_sync_q[1] || uv_sync_q[1]) && state_q == ST_MONITOR && !buck_wr_ok
			|=> buck1_fault_q;
	endproperty
	a_fault_pass: assert property (p_fault_pass) else $error("fault lost outside blanking");

	c_buck_write: cover property (buck_wr_ok ##1 buck1_blank_q);
	c_cut: cover property (ls_cfg_q[`LS_CUT_LSB] && !pf_n_s ##1 !sw_on_q[0]);
	c_apply: cover property (voltage_apply_alt ##1 $changed(buck1_vout_code_q));
	c_restart: cover property (state_q == ST_BLANK && buck_wr_ok);
	c_blank_end: cover property (state_q == ST_BLANK ##1 state_q == ST_MONITOR ##1 buck1_fault_q);

endmodule : loadswitch_buck1_config_regs

// ==== core/lsbc_params.svh ====
// Constants for the load-switch and buck-1 configuration registers.
// Assumes one 100 MHz register clock; included by the package and the core.
`ifndef LSBC_PARAMS_SVH
`define LSBC_PARAMS_SVH

// Register subaddresses
`define ADDR_LOAD_SWITCH_CONFIG 8'h15
`define ADDR_BUCK1_CONTROL      8'h16
`define ADDR_W                  8

// Reset values
`define RST_LOAD_SWITCH_CONFIG  8'h00
`define RST_BUCK1_CONTROL       8'h99

// Field positions, load-switch register
`define LS_CUT_LSB              3
`define LS_CUT_MSB              5
`define LS_DIS_LSB              0
`define LS_DIS_MSB              2
`define NUM_SWITCHES            3

// Field positions, buck-1 register
`define BUCK_PFM_BIT            7
`define BUCK_RSVD_BIT           6
`define BUCK_CODE_LSB           0
`define BUCK_CODE_MSB           5
`define BUCK_CODE_W             6

// Blanking time after a buck-1 write
`define BLANK_TIME_MS           5
`define CLK_PERIOD_NS           10
`define NS_PER_MS               1000000
`define BLANK_CNT_W             20

`endif

// ==== core/lsbc_pkg.sv ====
// Types for the load-switch and buck-1 configuration registers.
// Assumes lsbc_params.svh is on the include path.
`include "lsbc_params.svh"

package lsbc_pkg;

	typedef enum logic [0:0] {
		ST_MONITOR = 1'b0,
		ST_BLANK   = 1'b1
	} blank_state_t;

	typedef logic [`BUCK_CODE_W-1:0] vout_code_t;

endpackage : lsbc_pkg

// ==== verif/host_model.sv ====
// Host controller model: serial decoder side of the register block.
// Assumes ref_clk is the register clock; requests change only after rising edges.
`timescale 1ns/1ns

module host_model (
	// Clock
	input  wire logic       ref_clk,
	// Register access
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            unlock_ok,
	input  wire logic [7:0] reg_rdata_q,
	// Apply strobes
	output logic            voltage_apply_go,
	output logic            voltage_apply_alt
);
	initial begin
		{reg_wr, reg_rd, unlock_ok, voltage_apply_go, voltage_apply_alt} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Released lines show the inverse so a stale value is never mistaken for data
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ul);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		unlock_ok <= ul;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		unlock_ok <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata_q;
	endtask : rd

	// One-cycle go, or a short level on the alternative bit
	task automatic apply(input logic alt);
		@(posedge ref_clk);
		voltage_apply_go <= ~alt;
		voltage_apply_alt <= alt;
		@(posedge ref_clk);
		voltage_apply_go <= 1'b0;
		voltage_apply_alt <= 1'b0;
	endtask : apply
endmodule : host_model

// ==== verif/testbench.sv ====
// Self-checking bench for the load-switch and buck-1 registers.
// Assumes the host model and core files are compiled first.
`timescale 1ns/1ns
`include "lsbc_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module testbench;
	import lsbc_pkg::*;
	logic       ref_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] sw_on_req = 3'h0;
	logic       pf_n = 1'b1;
	logic       ov = 1'b0;
	logic       uv = 1'b0;
	logic       wr, rd, ul, go, alt, pse, fault, blank;
	logic [7:0] addr, wdata, rdata, d, v, a;
	logic [2:0] sw_on, sw_dis, e;
	vout_code_t code, cur;
	int         fail_count = 0;
	int         checks_done = 0;
	int         seed = 32'hF6F9;
	int         i;
	localparam int BLANK = 16;

	always #5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////////
	host_model i_host (.ref_clk(ref_clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
		.reg_wdata(wdata), .unlock_ok(ul), .reg_rdata_q(rdata),
		.voltage_apply_go(go), .voltage_apply_alt(alt));

	loadswitch_buck1_config_regs #(.BLANK_CYCLES(BLANK)) i_dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
		.reg_rdata_q(rdata), .unlock_ok(ul), .voltage_apply_go(go),
		.voltage_apply_alt(alt), .sw_on_req(sw_on_req), .power_fail_out_n(pf_n),
		.sw_on_q(sw_on), .sw_discharge_q(sw_dis), .pulse_skip_en_q(pse),
		.buck1_vout_code_q(code), .buck1_ov_raw(ov), .buck1_uv_raw(uv),
		.buck1_fault_q(fault), .buck1_blank_q(blank));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rd_exp(input logic [7:0] ad, input logic [7:0] dv);
		if (ad == `ADDR_LOAD_SWITCH_CONFIG) return dv & 8'h3F;
		if (ad == `ADDR_BUCK1_CONTROL) return dv & 8'hBF;
		return 8'h00;
	endfunction : rd_exp

	function automatic logic [2:0] on_exp(input logic [2:0] req, cut, input logic trip);
		return req & ~(cut & {3{trip}});
	endfunction : on_exp

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	initial begin
		#200000;
		fail_count++;
		results();
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		i_host.rd(8'h15, d);
		`CHK("reset 15", 8'h00, d)
		i_host.rd(8'h16, d);
		`CHK("reset 16", 8'h99, d)
		`CHK("reset code", 6'h19, code)
		`CHK("reset pfm", 1'b1, pse)
		i_host.wr(8'h16, 8'h00, 1'b0);
		i_host.rd(8'h16, d);
		`CHK("locked 16", 8'h99, d)
		i_host.wr(8'h15, 8'h3F, 1'b0);
		i_host.rd(8'h15, d);
		`CHK("locked 15", 8'h00, d)
		// Readback with reserved bits forced high on the first writes to 15 and 16, unmapped places included
		for (i = 0; i < 12; i++) begin
			a = (i % 3 == 2) ? 8'h14 + 8'(i % 4) * 8'h03 : 8'h15 + 8'(i % 2);
			v = (i < 2) ? 8'hFF : 8'($random(seed));
			i_host.wr(a, v, 1'b1);
			i_host.rd(a, d);
			`CHK("readback", rd_exp(a, v), d)
		end
		cur = 6'h19;
		ov <= 1'b1;
		for (i = 0; i < 4; i++) begin
			v = {i[0], 1'b0, (i == 1) ? 6'h3F : 6'($random(seed))};
			i_host.wr(8'h16, v, 1'b1);
			#1;
			`CHK("blank on", 1'b1, blank)
			`CHK("code held", cur, code)
			@(posedge ref_clk);
			#1;
			`CHK("pfm", v[7], pse)
			i_host.apply(i[1]);
			#1;
			`CHK("code applied", v[5:0], code)
			`CHK("fault blanked", 1'b0, fault)
			cur = v[5:0];
			// Write edge plus BLANK cycles: still blanked, fault masked
			repeat (BLANK - 3) @(posedge ref_clk);
			#1;
			`CHK("blank last", 1'b1, blank)
			`CHK("fault masked", 1'b0, fault)
			@(posedge ref_clk);
			#1;
			`CHK("blank off", 1'b0, blank)
			`CHK("fault seen", 1'b1, fault)
			{ov, uv} <= {i[0], ~i[0]};
		end
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'h3F : 8'($random(seed)) & 8'h3F;
			i_host.wr(8'h15, v, 1'b1);
			sw_on_req <= (i == 0) ? 3'h7 : 3'($random(seed));
			pf_n <= i[0];
			repeat (5) @(posedge ref_clk);
			#1;
			e = on_exp(sw_on_req, v[5:3], ~pf_n);
			`CHK("switch on", e, sw_on)
			`CHK("discharge", v[2:0] & ~e, sw_dis)
		end
		results();
	end
endmodule : testbench
